/* File: inc/wscp_pkg.sv */
/*
  types shared by the wind sensor configuration block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package wscp_pkg;

  typedef enum logic [1:0] {
    WSCP_FRAME_NONE,
    WSCP_FRAME_STXETX,
    WSCP_FRAME_NMEA
  } wscp_frame_t;

  typedef enum logic [1:0] {
    WSCP_HEAT_OFF,
    WSCP_HEAT_ON,
    WSCP_HEAT_AUTO,
    WSCP_HEAT_TEST
  } wscp_heat_t;

endpackage

/* File: inc/wscp_regs.svh */
/*
  register offsets, field limits, reset values and timing figures for the
  wind sensor configuration block.
  assumes byte addresses on an 8-bit register port, 32-bit data words.
*/
`ifndef WSCP_REGS_SVH
`define WSCP_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define WSCP_OFS_COHERENT   8'h00
`define WSCP_OFS_NORTH      8'h04
`define WSCP_OFS_LINE_RATE  8'h08
`define WSCP_OFS_CELL_VOLT  8'h0c
`define WSCP_OFS_MIRROR     8'h10
`define WSCP_OFS_WRAPPING   8'h14
`define WSCP_OFS_BODY_CORR  8'h18
`define WSCP_OFS_INVERTED   8'h1c
`define WSCP_OFS_WARM_FAULT 8'h20
`define WSCP_OFS_WARM_CTRL  8'h24
`define WSCP_OFS_CAL_STAMP  8'h28
`define WSCP_OFS_LOG_MODE   8'h2c
`define WSCP_OFS_FREE       8'h30
`define WSCP_OFS_TOTAL      8'h34
`define WSCP_OFS_UNREAD     8'h38
`define WSCP_OFS_PLAUS      8'h3c
`define WSCP_OFS_NMEA_OPT   8'h40
`define WSCP_OFS_AFAULT     8'h44
`define WSCP_OFS_SAMPLE     8'h48
`define WSCP_OFS_PROTOCOL   8'h4c
`define WSCP_OFS_STATUS     8'h50
`define WSCP_OFS_CHECKSUM   8'h54
`define WSCP_OFS_LABEL      8'h80
`define WSCP_LABEL_LEN      5'd31

// ----------------------------------------------------------------------
// limits and reset values
// ----------------------------------------------------------------------
`define WSCP_COH_MAX        32'd32
`define WSCP_COH_PER_RATE   32'd1000
`define WSCP_COH_RST        6'h01
`define WSCP_NORTH_MAX      32'd359
`define WSCP_SAMPLE_MIN     32'd4000
`define WSCP_SAMPLE_MAX     32'd40000
`define WSCP_SAMPLE_RST     16'h2710
`define WSCP_BODY_CORR_ON   32'd5
`define WSCP_LOG_RESTART    32'd55
`define WSCP_LOG_ERASE      32'd99
`define WSCP_LOG_TOTAL      16'h1000
`define WSCP_U16_MAX        32'd65535
`define WSCP_PLAUS_RST      16'h0014
`define WSCP_NMEA_OPT_MAX   32'd31
`define WSCP_BATT_LOW_MV    16'h09c4
`define WSCP_HEAT_ON_DC     16'sh002d
`define WSCP_HEAT_OFF_DC    16'sh0037
`define WSCP_CR             8'h0d

// ----------------------------------------------------------------------
// clock and line rates
// ----------------------------------------------------------------------
`define WSCP_CLK_HZ         32'd50000000
`define WSCP_RATE_STD       32'd9600
`define WSCP_RATE_NMEA      32'd4800

`endif

/* File: rtl/wscp_core.sv */
/*
  configuration parameter set of a two-axis ultrasonic wind sensor: range
  checked settings, line rate tick, echo request, frame checksum, heater
  control, fault output selection and data logger counters.
  assumes the command parser and the measurement path run on clk and hand
  in one-cycle pulses; registers are reached over a plain strobe port.
*/
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "wscp_regs.svh"

module wscp_core (
  input  wire logic               clk,              // 50 mhz clock
  input  wire logic               sys_rst,          // async reset, high
  input  wire logic [7:0]         addr,             // register byte address
  input  wire logic [31:0]        wrData,           // write data
  input  wire logic               wrStb,            // write strobe
  input  wire logic               rdStb,            // read strobe
  output      logic [31:0]        rdData,           // read data, cycle after rdStb
  input  wire logic [15:0]        cellVoltage,      // backup cell, mv
  input  wire logic               rxValid,          // received command byte
  input  wire logic [7:0]         rxByte,           // command byte
  input  wire logic               txStart,          // start of an output record
  input  wire logic               txValid,          // payload byte of the record
  input  wire logic [7:0]         txByte,           // payload byte
  input  wire logic signed [15:0] temperature,      // head temperature, 0.1 degc
  input  wire logic               measValid,        // one measurement done
  input  wire logic               measImplausible,  // measurement was implausible
  input  wire logic               heaterFault,      // heater malfunction seen
  input  wire logic               qualityError,     // quality check failed
  input  wire logic               logStore,         // data set to be logged
  input  wire logic               logReadOut,       // oldest unread set read out
  input  wire logic               calDone,          // calibration finished
  input  wire logic [31:0]        calTime,          // date and time of calibration
  output      logic               baudTick,         // one pulse per bit time
  output      logic               echoRequest,      // reflect the command line
  output      logic [1:0]         frameMode,        // wscp_frame_t encoding
  output      logic [7:0]         checksum,         // running record checksum
  output      logic [5:0]         coherentCount,    // samples averaged coherently
  output      logic [8:0]         northOffset,      // degrees added to direction
  output      logic               bodyCorrEn,       // head correction active
  output      logic               invertedMount,    // head points downwards
  output      logic               heaterOn,         // heater drive
  output      logic               analogError,      // analog outputs in error state
  output      logic [1:0]         analogFaultState, // 0 hold,1 offset,2 half,3 max
  output      logic               plausCheckEn,     // plausibility check active
  output      logic [15:0]        plausLimit,       // deviation limit
  output      logic [4:0]         nmeaOptions,      // nmea content select
  output      logic               logActive,        // logger storing data
  output      logic               logSerialEn       // serial output while logging
);

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // line rate code 1..10, zero for a value of 0, 4'hf when the value is not a legal rate
  function automatic logic [3:0] rateCode(input logic [31:0] v);
    case (v)
      32'd0:      rateCode = 4'h0;
      32'd300:    rateCode = 4'h1;
      32'd600:    rateCode = 4'h2;
      32'd1200:   rateCode = 4'h3;
      32'd2400:   rateCode = 4'h4;
      32'd4800:   rateCode = 4'h5;
      32'd9600:   rateCode = 4'h6;
      32'd19200:  rateCode = 4'h7;
      32'd38400:  rateCode = 4'h8;
      32'd57600:  rateCode = 4'h9;
      32'd115200: rateCode = 4'ha;
      default:    rateCode = 4'hf;
    endcase
  endfunction

  function automatic logic [31:0] rateValue(input logic [3:0] c);
    case (c)
      4'h1:    rateValue = 32'd300;
      4'h2:    rateValue = 32'd600;
      4'h3:    rateValue = 32'd1200;
      4'h4:    rateValue = 32'd2400;
      4'h5:    rateValue = 32'd4800;
      4'h6:    rateValue = 32'd9600;
      4'h7:    rateValue = 32'd19200;
      4'h8:    rateValue = 32'd38400;
      4'h9:    rateValue = 32'd57600;
      4'ha:    rateValue = 32'd115200;
      default: rateValue = 32'd0;
    endcase
  endfunction

  function automatic logic isWr(input logic [7:0] ofs);
    isWr = wrStb && (addr == ofs);
  endfunction

  // ----------------------------------------------------------------------
  // stored settings
  // ----------------------------------------------------------------------
  logic [3:0]  lineRate_q;
  logic        inputMirroring_q;
  logic [1:0]  outputWrapping_q;
  logic        warmingFaultReport_q;
  logic [1:0]  warmingControl_q;
  logic [31:0] calibrationStamp_q;
  logic [6:0]  loggingMode_q;
  logic [15:0] sampleRate_q;
  logic        nmeaProto_q;
  logic        rejected_q;
  logic [7:0]  configLabel_q [0:30];
  logic [15:0] storeUsed_q;
  logic [15:0] storeUnread_q;
  logic        iced_q;
  logic        powerUp_q;
  logic [17:0] baudCnt_q;
  logic        labelHit;
  logic [4:0]  labelIdx;
  logic [31:0] coherentLimit;

  assign labelIdx = addr[6:2];
  assign labelHit = (addr[7] == 1'b1) && (addr[1:0] == 2'b00) && (labelIdx < `WSCP_LABEL_LEN);
  assign coherentLimit = {16'h0000, sampleRate_q} / `WSCP_COH_PER_RATE;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coherentCount <= `WSCP_COH_RST;
      sampleRate_q  <= `WSCP_SAMPLE_RST;
    end else if (isWr(`WSCP_OFS_COHERENT)) begin
      if (wrData >= 32'd1 && wrData <= `WSCP_COH_MAX && wrData <= coherentLimit) begin
        coherentCount <= wrData[5:0];
      end
    end else if (isWr(`WSCP_OFS_SAMPLE)) begin
      if (wrData >= `WSCP_SAMPLE_MIN && wrData <= `WSCP_SAMPLE_MAX) begin
        sampleRate_q <= wrData[15:0];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      northOffset      <= 9'h000;
      lineRate_q       <= 4'h0;
      inputMirroring_q <= 1'b0;
      outputWrapping_q <= 2'h0;
      bodyCorrEn       <= 1'b0;
      invertedMount    <= 1'b0;
      nmeaProto_q      <= 1'b0;
    end else if (wrStb) begin
      if (isWr(`WSCP_OFS_NORTH) && wrData <= `WSCP_NORTH_MAX) begin
        northOffset <= wrData[8:0];
      end
      if (isWr(`WSCP_OFS_LINE_RATE) && rateCode(wrData) != 4'hf) begin
        lineRate_q <= rateCode(wrData);
      end
      if (isWr(`WSCP_OFS_MIRROR) && wrData <= 32'd1) begin
        inputMirroring_q <= wrData[0];
      end
      if (isWr(`WSCP_OFS_WRAPPING) && (wrData == 32'd0 || wrData == 32'd2)) begin
        outputWrapping_q <= wrData[1:0];
      end
      if (isWr(`WSCP_OFS_BODY_CORR) && (wrData == 32'd0 || wrData == `WSCP_BODY_CORR_ON)) begin
        bodyCorrEn <= (wrData == `WSCP_BODY_CORR_ON);
      end
      if (isWr(`WSCP_OFS_INVERTED) && wrData <= 32'd1) begin
        invertedMount <= wrData[0];
      end
      if (isWr(`WSCP_OFS_PROTOCOL) && wrData <= 32'd1) begin
        nmeaProto_q <= wrData[0];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      warmingFaultReport_q <= 1'b0;
      warmingControl_q     <= 2'h0;
      analogFaultState     <= 2'h0;
      plausLimit           <= `WSCP_PLAUS_RST;
      nmeaOptions          <= 5'h00;
    end else if (wrStb) begin
      if (isWr(`WSCP_OFS_WARM_FAULT) && wrData <= 32'd1) begin
        warmingFaultReport_q <= wrData[0];
      end
      if (isWr(`WSCP_OFS_WARM_CTRL) && wrData <= 32'd3) begin
        warmingControl_q <= wrData[1:0];
      end
      if (isWr(`WSCP_OFS_AFAULT) && wrData <= 32'd3) begin
        analogFaultState <= wrData[1:0];
      end
      if (isWr(`WSCP_OFS_PLAUS) && wrData <= `WSCP_U16_MAX) begin
        plausLimit <= wrData[15:0];
      end
      if (isWr(`WSCP_OFS_NMEA_OPT) && wrData <= `WSCP_NMEA_OPT_MAX) begin
        nmeaOptions <= wrData[4:0];
      end
    end
  end

  // label bytes live in an array so a reset does not need 31 wide clears
  always_ff @(posedge clk) begin
    if (wrStb && labelHit) begin
      configLabel_q[labelIdx] <= wrData[7:0];
    end
  end

  // a write that the table would take but whose value is out of range, or a
  // write to a read-only or unmapped word, sets this sticky flag until the status is read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rejected_q <= 1'b0;
    end else if (wrStb && wrRefused()) begin
      rejected_q <= 1'b1;
    end else if (rdStb && addr == `WSCP_OFS_STATUS) begin
      rejected_q <= 1'b0;
    end
  end

  function automatic logic wrRefused();
    case (addr)
      `WSCP_OFS_COHERENT:   wrRefused = !(wrData >= 32'd1 && wrData <= `WSCP_COH_MAX
                                          && wrData <= coherentLimit);
      `WSCP_OFS_SAMPLE:     wrRefused = !(wrData >= `WSCP_SAMPLE_MIN && wrData <= `WSCP_SAMPLE_MAX);
      `WSCP_OFS_NORTH:      wrRefused = wrData > `WSCP_NORTH_MAX;
      `WSCP_OFS_LINE_RATE:  wrRefused = rateCode(wrData) == 4'hf;
      `WSCP_OFS_MIRROR,
      `WSCP_OFS_INVERTED,
      `WSCP_OFS_PROTOCOL,
      `WSCP_OFS_WARM_FAULT: wrRefused = wrData > 32'd1;
      `WSCP_OFS_WRAPPING:   wrRefused = !(wrData == 32'd0 || wrData == 32'd2);
      `WSCP_OFS_BODY_CORR:  wrRefused = !(wrData == 32'd0 || wrData == `WSCP_BODY_CORR_ON);
      `WSCP_OFS_WARM_CTRL,
      `WSCP_OFS_AFAULT:     wrRefused = wrData > 32'd3;
      `WSCP_OFS_PLAUS:      wrRefused = wrData > `WSCP_U16_MAX;
      `WSCP_OFS_NMEA_OPT:   wrRefused = wrData > `WSCP_NMEA_OPT_MAX;
      `WSCP_OFS_LOG_MODE:   wrRefused = !(wrData <= 32'd2 || wrData == `WSCP_LOG_RESTART
                                          || wrData == `WSCP_LOG_ERASE);
      default:              wrRefused = !labelHit; // includes the calibration stamp
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // calibration stamp
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      calibrationStamp_q <= 32'h00000000;
    end else if (calDone) begin
      calibrationStamp_q <= calTime;
    end
  end

  // ----------------------------------------------------------------------
  // line rate tick
  // ----------------------------------------------------------------------
  logic [31:0] effRate;
  logic [17:0] baudDiv;

  always_comb begin
    if (lineRate_q == 4'h0) begin
      effRate = nmeaProto_q ? `WSCP_RATE_NMEA : `WSCP_RATE_STD;
    end else begin
      effRate = rateValue(lineRate_q);
    end
  end

  // 50 mhz / 300 fits in 18 bits; the divide is a constant table in practice
  assign baudDiv = 18'(`WSCP_CLK_HZ / effRate);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      baudCnt_q <= 18'h00000;
      baudTick  <= 1'b0;
    end else if (baudCnt_q >= baudDiv - 18'h00001) begin
      baudCnt_q <= 18'h00000;
      baudTick  <= 1'b1;
    end else begin
      baudCnt_q <= baudCnt_q + 18'h00001;
      baudTick  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // echo and framing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      echoRequest <= 1'b0;
    end else begin
      echoRequest <= inputMirroring_q && rxValid && (rxByte == `WSCP_CR);
    end
  end

  wscp_pkg::wscp_frame_t frameSel;

  always_comb begin
    if (outputWrapping_q == 2'h0) begin
      frameSel = wscp_pkg::WSCP_FRAME_NONE;
    end else if (nmeaProto_q) begin
      frameSel = wscp_pkg::WSCP_FRAME_NMEA;
    end else begin
      frameSel = wscp_pkg::WSCP_FRAME_STXETX;
    end
  end

  // both framings use an xor over the payload; the framer prints it as two hex digits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frameMode <= 2'h0;
      checksum  <= 8'h00;
    end else begin
      frameMode <= frameSel;
      if (txStart) begin
        checksum <= 8'h00;
      end else if (txValid && frameSel != wscp_pkg::WSCP_FRAME_NONE) begin
        checksum <= checksum ^ txByte;
      end
    end
  end

  // ----------------------------------------------------------------------
  // heater and analog error
  // ----------------------------------------------------------------------
  wscp_pkg::wscp_heat_t heatMode;
  assign heatMode = wscp_pkg::wscp_heat_t'(warmingControl_q);

  // icing can only be assumed until the first plausible measurement
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerUp_q <= 1'b1;
      iced_q    <= 1'b0;
    end else begin
      if (measValid && !measImplausible) begin
        powerUp_q <= 1'b0;
      end
      if (heatMode != wscp_pkg::WSCP_HEAT_AUTO) begin
        iced_q <= 1'b0;
      end else if (powerUp_q && measValid && measImplausible) begin
        iced_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      heaterOn <= 1'b0;
    end else begin
      case (heatMode)
        wscp_pkg::WSCP_HEAT_ON:   heaterOn <= 1'b1;
        wscp_pkg::WSCP_HEAT_TEST: heaterOn <= ~heaterOn;
        wscp_pkg::WSCP_HEAT_AUTO: begin
          if (iced_q || temperature < `WSCP_HEAT_ON_DC) begin
            heaterOn <= 1'b1;
          end else if (temperature > `WSCP_HEAT_OFF_DC) begin
            heaterOn <= 1'b0;
          end
        end
        default:                  heaterOn <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      analogError  <= 1'b0;
      plausCheckEn <= 1'b0;
    end else begin
      plausCheckEn <= (plausLimit != 16'h0000);
      analogError  <= (warmingFaultReport_q && heaterOn && heaterFault)
                      || qualityError;
    end
  end

  // ----------------------------------------------------------------------
  // data logger counters
  // ----------------------------------------------------------------------
  logic logOn;
  assign logOn = (loggingMode_q != 7'h00);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      loggingMode_q <= 7'h00;
      storeUsed_q   <= 16'h0000;
      storeUnread_q <= 16'h0000;
    end else if (isWr(`WSCP_OFS_LOG_MODE) && !wrRefused()) begin
      loggingMode_q <= wrData[6:0];
      if (wrData == `WSCP_LOG_ERASE) begin
        storeUsed_q   <= 16'h0000;
        storeUnread_q <= 16'h0000;
      end else if (wrData == `WSCP_LOG_RESTART) begin
        storeUnread_q <= storeUsed_q;
      end
    end else begin
      if (logOn && logStore && storeUsed_q != `WSCP_LOG_TOTAL) begin
        storeUsed_q <= storeUsed_q + 16'h0001;
      end
      if (logOn && logStore && storeUsed_q != `WSCP_LOG_TOTAL && !logReadOut) begin
        storeUnread_q <= storeUnread_q + 16'h0001;
      end else if (logReadOut && storeUnread_q != 16'h0000
                   && !(logOn && logStore && storeUsed_q != `WSCP_LOG_TOTAL)) begin
        storeUnread_q <= storeUnread_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      logActive   <= 1'b0;
      logSerialEn <= 1'b1;
    end else begin
      logActive   <= logOn;
      logSerialEn <= (loggingMode_q != 7'h01);
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData <= 32'h00000000;
    end else if (rdStb) begin
      case (addr)
        `WSCP_OFS_COHERENT:   rdData <= {26'h0, coherentCount};
        `WSCP_OFS_NORTH:      rdData <= {23'h0, northOffset};
        `WSCP_OFS_LINE_RATE:  rdData <= rateValue(lineRate_q);
        `WSCP_OFS_CELL_VOLT:  rdData <= {16'h0, cellVoltage};
        `WSCP_OFS_MIRROR:     rdData <= {31'h0, inputMirroring_q};
        `WSCP_OFS_WRAPPING:   rdData <= {30'h0, outputWrapping_q};
        `WSCP_OFS_BODY_CORR:  rdData <= bodyCorrEn ? `WSCP_BODY_CORR_ON : 32'h0;
        `WSCP_OFS_INVERTED:   rdData <= {31'h0, invertedMount};
        `WSCP_OFS_WARM_FAULT: rdData <= {31'h0, warmingFaultReport_q};
        `WSCP_OFS_WARM_CTRL:  rdData <= {30'h0, warmingControl_q};
        `WSCP_OFS_CAL_STAMP:  rdData <= calibrationStamp_q;
        `WSCP_OFS_LOG_MODE:   rdData <= {25'h0, loggingMode_q};
        `WSCP_OFS_FREE:       rdData <= {16'h0, `WSCP_LOG_TOTAL - storeUsed_q};
        `WSCP_OFS_TOTAL:      rdData <= {16'h0, `WSCP_LOG_TOTAL};
        `WSCP_OFS_UNREAD:     rdData <= {16'h0, storeUnread_q};
        `WSCP_OFS_PLAUS:      rdData <= {16'h0, plausLimit};
        `WSCP_OFS_NMEA_OPT:   rdData <= {27'h0, nmeaOptions};
        `WSCP_OFS_AFAULT:     rdData <= {30'h0, analogFaultState};
        `WSCP_OFS_SAMPLE:     rdData <= {16'h0, sampleRate_q};
        `WSCP_OFS_PROTOCOL:   rdData <= {31'h0, nmeaProto_q};
        `WSCP_OFS_STATUS:     rdData <= {28'h0, rejected_q, (cellVoltage < `WSCP_BATT_LOW_MV),
                                         analogError, heaterOn};
        `WSCP_OFS_CHECKSUM:   rdData <= {24'h0, checksum};
        default:              rdData <= labelHit ? {24'h0, configLabel_q[labelIdx]} : 32'h0;
      endcase
    end
  end

endmodule

/* File: testbench/wind_sensor_config_params_bench.sv */
/* bench for wscp_core: register walk against an integer model, then line rate,
   echo, checksum, logger and stamp; assumes the host model drives rx bytes */
`timescale 1ns/100ps
module wind_sensor_config_params_bench;
  logic        clk = 0, sys_rst = 1, wrStb = 0, rdStb = 0, txStart = 0, txValid = 0;
  logic        logStore = 0, logReadOut = 0, calDone = 0, rxValid, baudTick, echoRequest;
  logic        measValid = 0, measImplausible = 0, heaterFault = 0;
  logic [7:0]  addr = 0, txByte = 0, rxByte, checksum, ck;
  logic [31:0] wrData = 0, calTime = 0, rdData, v, m [256];
  logic [15:0] cellVoltage = 16'h09c3;
  logic [1:0]  frameMode;
  logic [7:0]  al [16] = '{0, 4, 8, 12, 16, 20, 24, 28, 32, 36, 40, 44, 60, 64, 68, 96};
  int          vl [12] = '{0, 1, 2, 3, 5, 31, 32, 55, 99, 359, 360, 65536};
  int          rt [3] = '{0, 115200, 0};
  int          bad_count = 0, total_checks = 0, cyc = 0, echoes = 0;
  time         t0;
  always #10 clk = ~clk;
  wscp_core wscp_core_i (.clk, .sys_rst, .addr, .wrData, .wrStb, .rdStb, .rdData, .cellVoltage,
    .rxValid, .rxByte, .txStart, .txValid, .txByte, .temperature(16'sh0064), .measValid,
    .measImplausible, .heaterFault, .qualityError(1'b0), .logStore, .logReadOut,
    .calDone, .calTime, .baudTick, .echoRequest, .frameMode, .checksum, .coherentCount(),
    .northOffset(), .bodyCorrEn(), .invertedMount(), .heaterOn(), .analogError(),
    .analogFaultState(), .plausCheckEn(), .plausLimit(), .nmeaOptions(), .logActive(),
    .logSerialEn());
  wscp_host wscp_host_i (.clk, .rxValid, .rxByte);
  // ----------------------------------------------------------------------
  // model and bus tasks
  // ----------------------------------------------------------------------
  function automatic bit ok(input logic [7:0] a, input logic [31:0] d);
    case (a)
      0: return d >= 1 && d <= 10;
      4: return d <= 359;
      8: return d inside {0, 300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
      16, 28, 32: return d <= 1;
      20: return d inside {0, 2};
      24: return d inside {0, 5};
      36, 68: return d <= 3;
      44: return d inside {0, 1, 2, 55, 99};
      60: return d <= 65535;
      64: return d <= 31;
      default: return 0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) wrStb <= 1;
    addr <= a;
    wrData <= d;
    @(posedge clk) wrStb <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) rdStb <= 1;
    addr <= a;
    @(posedge clk) rdStb <= 0;
    #1 chk(rdData, e);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    echoes <= echoes + echoRequest;
    if (cyc == 60000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    v = $urandom(4181);
    foreach (m[k]) m[k] = 0;
    m[0] = 1;
    m[12] = 32'h09c3;
    m[60] = 20;
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    foreach (al[k]) for (int j = 0; j < 13; j++) begin
      v = (j < 12) ? vl[j] : $urandom % 70000;
      wr(al[k], v);
      if (ok(al[k], v)) m[al[k]] = v;
      rd(al[k], m[al[k]]);
    end
    wr(36, 1);
    rd(80, 32'hd);
    rd(80, 32'h5);
    heaterFault <= 1;
    wr(32, 1);
    rd(80, 32'h7);
    heaterFault <= 0;
    wr(36, 2);
    rd(80, 32'h4);
    measValid <= 1;
    measImplausible <= 1;
    @(posedge clk) measValid <= 0;
    rd(80, 32'h5);
    foreach (rt[k]) begin
      if (k == 2) wr(76, 1);
      wr(8, rt[k]);
      v = rt[k] ? rt[k] : ((k == 2) ? 4800 : 9600);
      @(posedge baudTick);
      @(posedge baudTick) t0 = $time;
      @(posedge baudTick) chk(32'(($time - t0) / 20), 50000000 / v);
    end
    wr(16, 1);
    wscp_host_i.send(8'h41);
    wscp_host_i.send(8'h0d);
    wr(16, 0);
    wscp_host_i.send(8'h0d);
    @(posedge clk) chk(echoes, 1);
    wr(20, 2);
    @(posedge clk) txStart <= 1;
    @(posedge clk) txStart <= 0;
    ck = 0;
    repeat (4) begin
      v = $urandom;
      ck ^= v[7:0];
      @(posedge clk) txValid <= 1;
      txByte <= v[7:0];
    end
    @(posedge clk) txValid <= 0;
    rd(84, ck);
    chk(frameMode, 2);
    wr(76, 0);
    @(posedge clk) #1 chk(frameMode, 1);
    wr(44, 99);
    repeat (3) begin
      @(posedge clk) logStore <= 1;
      @(posedge clk) logStore <= 0;
    end
    @(posedge clk) logReadOut <= 1;
    calDone <= 1;
    calTime <= v;
    @(posedge clk) logReadOut <= 0;
    calDone <= 0;
    rd(56, 2);
    rd(48, 4093);
    rd(52, 4096);
    rd(40, v);
    wr(248, 32'h7a);
    rd(248, 32'h7a);
    results();
  end
endmodule

/* File: testbench/wscp_core_monitor.sv */
/* port checker for wscp_core, bound at its foot; assumes a single clock domain */
`timescale 1ns/100ps
module wscp_core_monitor (
  input wire logic        clk,           // clock
  input wire logic        sys_rst,       // reset
  input wire logic        rxValid,       // rx byte
  input wire logic        echoRequest,   // echo
  input wire logic        baudTick,      // bit tick
  input wire logic [1:0]  frameMode,     // framing
  input wire logic [5:0]  coherentCount, // averaging
  input wire logic [8:0]  northOffset,   // azimuth
  input wire logic [15:0] plausLimit,    // limit
  input wire logic        plausCheckEn,  // check on
  input wire logic        logActive,     // logging
  input wire logic        logSerialEn    // serial on
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_coh_range: assert property (coherentCount inside {[6'd1:6'd32]}) else $error("count");
  a_north_range: assert property (northOffset <= 9'd359) else $error("offset");
  a_tick_gap: assert property (baudTick |=> !baudTick [*8]) else $error("tick");
  a_echo_cause: assert property (echoRequest |-> $past(rxValid)) else $error("echo");
  a_frame_code: assert property (frameMode != 2'd3) else $error("frame");
  a_log_serial: assert property (!logSerialEn |-> logActive) else $error("logger");
  a_check_lag: assert property (!$past(sys_rst) |-> plausCheckEn == ($past(plausLimit) != 16'h0000))
    else $error("check");
  a_check_off: assert property (plausLimit == 16'h0000 |=> !plausCheckEn) else $error("off");
endmodule
bind wscp_core wscp_core_monitor wscp_core_monitor_i (.clk, .sys_rst, .rxValid, .echoRequest,
  .baudTick, .frameMode, .coherentCount, .northOffset, .plausLimit, .plausCheckEn, .logActive,
  .logSerialEn);

/* File: testbench/wscp_host.sv */
/* host terminal model: sends command bytes; assumes the bench calls send */
`timescale 1ns/100ps
module wscp_host (
  input  wire logic       clk,     // clock
  output      logic       rxValid, // byte strobe
  output      logic [7:0] rxByte   // byte
);
  initial rxValid = 1'b0;
  initial rxByte = 8'h00;
  task automatic send(input logic [7:0] b);
    @(posedge clk) rxValid <= 1'b1;
    rxByte <= b;
    @(posedge clk) rxValid <= 1'b0;
    rxByte <= ~b; // released line must not show a stale byte
  endtask
endmodule
